// ### design/epm_pkg.sv
package epm_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int WORDS = 128;
    localparam int CLK_HZ = 20000000;
    // Programming time is this many periods of the slow programming clock.
    localparam int PROG_PERIODS = 1024;
    // Host strobe pulse width minimum, in ns.
    localparam int STROBE_MIN_NS = 175;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Chip select to strobe lead minimum, in ns.
    localparam int CS_LEAD_NS = 100;
    localparam int CS_LEAD_CYC = (CS_LEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Address float to output gate minimum, in ns.
    localparam int FLOAT_NS = 20;
    localparam int FLOAT_CYC_RAW = (FLOAT_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int FLOAT_CYC = (FLOAT_CYC_RAW < 1) ? 1 : FLOAT_CYC_RAW;
    // Address and data setup ahead of the capturing strobe edge, in ns.
    localparam int SETUP_NS = 175;
    localparam int SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Write data hold after the write strobe rises, in ns.
    localparam int HOLD_NS = 50;
    localparam int HOLD_CYC = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage

// ### design/epm_if.sv
`timescale 1ns/1ns
interface epm_if;
    logic [epm_pkg::ADDR_W-1:0] addr;
    logic [epm_pkg::DATA_W-1:0] data_h2d;
    logic                       data_h2d_oe;
    logic [epm_pkg::DATA_W-1:0] data_d2h;
    logic                       data_d2h_oe;
    logic                       chip_select_n;
    logic                       output_gate_n;
    logic                       write_strobe_n;
    logic                       address_latch_strobe;
    logic                       prog_clk;
    logic                       program_status;
    // Resolved level of the shared data lines; a floating bus reads as all ones.
    wire  [epm_pkg::DATA_W-1:0] data_bus = data_h2d_oe ? data_h2d :
                                           (data_d2h_oe ? data_d2h : '1);
    modport dev (input addr, input data_bus, input chip_select_n, input output_gate_n,
                 input write_strobe_n, input address_latch_strobe, input prog_clk,
                 output data_d2h, output data_d2h_oe, output program_status);
    modport host (output addr, output data_h2d, output data_h2d_oe, output chip_select_n,
                  output output_gate_n, output write_strobe_n,
                  output address_latch_strobe, output prog_clk,
                  input data_bus, input program_status);
endinterface

// ### design/epm_device.sv
`timescale 1ns/1ns
// Summary of operation
// - Multiplexed: address captured on latch strobe fall.
// - Host swaps address for data after latching.
// - Write data taken on strobe rise; busy follows.
// - Separate bus: strobes tied, address fall, data rise.
// - Busy lasts 1024 programming clock periods.
// - Timer counts the slow programming clock input.
// - Strobes and reads ignored while programming.
// - Host floats address before output gate.
// - Read byte driven until gate or select rises.
// - Separate-bus read address held by host.
// - Separate read data follows address; floats promptly.
// - Host strobe pulses 175 ns to 100 us.
// - Host separate-write setup and select lead.
// - Host multiplexed select lead and data hold.
// - Host keeps gate high, no write glitch.
// - Deselected device floats data, ignores strobes.
// - Status low while busy, high when readable.
module epm_device #(
    parameter int PROG_PERIODS = epm_pkg::PROG_PERIODS,
    parameter bit MUX_MODE     = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    epm_if.dev        bus
);
    initial begin
        if (PROG_PERIODS < 2 || PROG_PERIODS > 65535) begin
            $error("PROG_PERIODS out of range");
        end
        // The multiplexed address shares the data lines, so it must fit on them.
        if (epm_pkg::ADDR_W > epm_pkg::DATA_W) begin
            $error("address wider than data lines");
        end
        if (epm_pkg::WORDS != (1 << epm_pkg::ADDR_W)) begin
            $error("array depth does not match address width");
        end
    end

    typedef enum logic [1:0] {EPM_IDLE, EPM_ARMED, EPM_PROG} epm_state_t;

    // All pins come from the far party and pass two flip-flops first.
    localparam int SW = 4 + epm_pkg::ADDR_W + epm_pkg::DATA_W;
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    logic          pclk_s1_ff;
    logic          pclk_s2_ff;
    logic          pclk_s3_ff;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else if (clk_en) begin
            sync1_ff <= {bus.chip_select_n, bus.output_gate_n, bus.write_strobe_n,
                         bus.address_latch_strobe, bus.addr, bus.data_bus};
            sync2_ff <= sync1_ff;
        end
    end

    // The timing input has its own stages; the third one only serves to find edges.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pclk_s1_ff <= 1'b0;
            pclk_s2_ff <= 1'b0;
            pclk_s3_ff <= 1'b0;
        end else if (clk_en) begin
            pclk_s1_ff <= bus.prog_clk;
            pclk_s2_ff <= pclk_s1_ff;
            pclk_s3_ff <= pclk_s2_ff;
        end
    end

    logic                       cs_n;
    logic                       gate_n;
    logic                       we_n;
    logic                       ale;
    logic [epm_pkg::ADDR_W-1:0] addr_s;
    logic [epm_pkg::DATA_W-1:0] data_s;
    assign {cs_n, gate_n, we_n, ale, addr_s, data_s} = sync2_ff;

    logic we_d_ff;
    logic ale_d_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            we_d_ff  <= 1'b1;
            ale_d_ff <= 1'b0;
        end else if (clk_en) begin
            we_d_ff  <= we_n;
            ale_d_ff <= ale;
        end
    end

    logic       state_idle;
    epm_state_t state_ff;
    assign state_idle = (state_ff != EPM_PROG);
    // Deselected or busy, every strobe is ignored.
    logic live;
    assign live = !cs_n && state_idle;
    logic ale_fall;
    logic we_fall;
    logic we_rise;
    assign ale_fall = live && ale_d_ff && !ale;
    assign we_fall  = live && we_d_ff && !we_n;
    assign we_rise  = live && !we_d_ff && we_n;

    logic [epm_pkg::ADDR_W-1:0] addr_lat_ff;
    logic [epm_pkg::DATA_W-1:0] data_lat_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_lat_ff <= '0;
        end else if (clk_en) begin
            if (MUX_MODE && ale_fall) begin
                addr_lat_ff <= data_s[epm_pkg::ADDR_W-1:0];
            end else if (!MUX_MODE && we_fall) begin
                addr_lat_ff <= addr_s;
            end
        end
    end

    // The array holds its contents across reset, as a real nonvolatile part would.
    logic [epm_pkg::DATA_W-1:0] mem_ff [epm_pkg::WORDS];
    logic [15:0]                tmr_ff;
    logic                       pclk_rise;
    assign pclk_rise = pclk_s2_ff && !pclk_s3_ff;
    logic commit;
    assign commit = (state_ff == EPM_PROG) && pclk_rise
                    && (tmr_ff == 16'(PROG_PERIODS - 1));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= EPM_IDLE;
        end else if (clk_en) begin
            unique case (state_ff)
                EPM_IDLE: begin
                    if (we_fall) begin
                        state_ff <= EPM_ARMED;
                    end
                end
                EPM_ARMED: begin
                    if (cs_n) begin
                        state_ff <= EPM_IDLE;
                    end else if (we_rise) begin
                        state_ff <= EPM_PROG;
                    end
                end
                EPM_PROG: begin
                    if (commit) begin
                        state_ff <= EPM_IDLE;
                    end
                end
                default: state_ff <= EPM_IDLE;
            endcase
        end
    end

    // The count restarts from zero on every entry, whatever the last cycle left behind.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tmr_ff <= '0;
        end else if (clk_en) begin
            if (state_ff != EPM_PROG) begin
                tmr_ff <= '0;
            end else if (pclk_rise) begin
                tmr_ff <= tmr_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data_lat_ff <= '0;
        end else if (clk_en && state_ff == EPM_ARMED && we_rise) begin
            data_lat_ff <= data_s;
        end
    end

    // The old word stays in the array until the whole programming time has run out.
    always_ff @(posedge core_clk) begin
        if (clk_en && commit) begin
            mem_ff[addr_lat_ff] <= data_lat_ff;
        end
    end

    // Status drops four cycles after the write strobe pin edge, well inside the status delay.
    logic status_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_ff <= 1'b1;
        end else if (clk_en) begin
            status_ff <= (state_ff != EPM_PROG);
        end
    end
    assign bus.program_status = status_ff;

    logic [epm_pkg::ADDR_W-1:0] rd_addr;
    assign rd_addr = MUX_MODE ? addr_lat_ff : addr_s;
    logic [epm_pkg::DATA_W-1:0] dout_ff;
    logic                       doe_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dout_ff <= '0;
            doe_ff  <= 1'b0;
        end else if (clk_en) begin
            doe_ff  <= live && !gate_n && we_n;
            dout_ff <= mem_ff[rd_addr];
        end
    end
    assign bus.data_d2h    = dout_ff;
    assign bus.data_d2h_oe = doe_ff;
endmodule

// ### design/epm_host.sv
`timescale 1ns/1ns
module epm_host #(
    parameter int PCLK_DIV = 1000,
    parameter bit MUX_MODE = 1'b1
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [epm_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [epm_pkg::DATA_W-1:0] req_wdata,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [epm_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                            dev_busy,
    epm_if.host                             bus
);
    initial begin
        if (PCLK_DIV < 2 || PCLK_DIV > 65535) begin
            $error("PCLK_DIV out of range");
        end
    end

    typedef enum logic [2:0] {EH_IDLE, EH_SEL, EH_ALE, EH_FLOAT, EH_STROBE, EH_HOLD,
                              EH_READ} eh_state_t;

    localparam int TW = 8;
    localparam logic [TW-1:0] T_LEAD = TW'(epm_pkg::CS_LEAD_CYC);
    localparam logic [TW-1:0] T_PULSE = TW'(epm_pkg::STROBE_MIN_CYC + 1);
    localparam logic [TW-1:0] T_SETUP = TW'(epm_pkg::SETUP_CYC + 1);
    localparam logic [TW-1:0] T_FLOAT = TW'(epm_pkg::FLOAT_CYC);
    localparam logic [TW-1:0] T_HOLD = TW'(epm_pkg::HOLD_CYC);
    // Read wait covers the 300 ns access plus the device's input synchronisers.
    localparam logic [TW-1:0] T_READ = 8'h0A;
    // The device drops its status some cycles after the strobe rises and we see that two
    // cycles later; holding that long keeps a new request off a device that will ignore it.
    localparam logic [TW-1:0] T_SETTLE = 8'h06;

    // Programming clock divider, free running.
    logic [15:0] pdiv_ff;
    logic        pclk_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pdiv_ff <= '0;
            pclk_ff <= 1'b0;
        end else if (clk_en) begin
            if (pdiv_ff == 16'(PCLK_DIV / 2 - 1)) begin
                pdiv_ff <= '0;
                pclk_ff <= !pclk_ff;
            end else begin
                pdiv_ff <= pdiv_ff + 16'h0001;
            end
        end
    end
    assign bus.prog_clk = pclk_ff;

    logic st_s1_ff;
    logic st_s2_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_s1_ff <= 1'b1;
            st_s2_ff <= 1'b1;
        end else if (clk_en) begin
            st_s1_ff <= bus.program_status;
            st_s2_ff <= st_s1_ff;
        end
    end
    assign dev_busy = !st_s2_ff;

    eh_state_t                  st_ff;
    logic [TW-1:0]              cnt_ff;
    logic                       wr_ff;
    logic [epm_pkg::ADDR_W-1:0] a_ff;
    logic [epm_pkg::DATA_W-1:0] d_ff;
    logic                       done;
    assign done = (cnt_ff == '0);
    assign req_ready = (st_ff == EH_IDLE) && st_s2_ff;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff     <= EH_IDLE;
            cnt_ff    <= '0;
            wr_ff     <= 1'b0;
            a_ff      <= '0;
            d_ff      <= '0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            if (!done) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
            unique case (st_ff)
                EH_IDLE: begin
                    if (req_valid && req_ready) begin
                        wr_ff  <= req_write;
                        a_ff   <= req_addr;
                        d_ff   <= req_wdata;
                        cnt_ff <= T_LEAD + T_SETUP;
                        st_ff  <= EH_SEL;
                    end
                end
                EH_SEL: if (done) begin
                    cnt_ff <= T_PULSE;
                    st_ff  <= (MUX_MODE) ? EH_ALE : (wr_ff ? EH_STROBE : EH_READ);
                end
                EH_ALE: if (done) begin
                    cnt_ff <= wr_ff ? T_SETUP : T_FLOAT;
                    st_ff  <= EH_FLOAT;
                end
                EH_FLOAT: if (done) begin
                    cnt_ff <= wr_ff ? T_PULSE : T_READ;
                    st_ff  <= wr_ff ? EH_STROBE : EH_READ;
                end
                EH_STROBE: if (done) begin
                    cnt_ff <= T_HOLD + T_SETTLE;
                    st_ff  <= EH_HOLD;
                end
                EH_HOLD: if (done) begin
                    st_ff <= EH_IDLE;
                end
                EH_READ: if (done) begin
                    if (MUX_MODE || cnt_ff == '0) begin
                        rsp_valid <= 1'b1;
                        rsp_rdata <= bus.data_bus;
                        st_ff     <= EH_IDLE;
                    end
                end
                default: st_ff <= EH_IDLE;
            endcase
        end
    end

    // Strobe and select pins are registered so no glitch reaches the device.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus.chip_select_n        <= 1'b1;
            bus.output_gate_n        <= 1'b1;
            bus.write_strobe_n       <= 1'b1;
            bus.address_latch_strobe <= !MUX_MODE;
            bus.addr                 <= '0;
            bus.data_h2d             <= '0;
            bus.data_h2d_oe          <= 1'b0;
        end else if (clk_en) begin
            bus.chip_select_n  <= (st_ff == EH_IDLE) && !(req_valid && req_ready);
            bus.output_gate_n  <= !(st_ff == EH_READ && done == 1'b0);
            bus.addr           <= (st_ff == EH_IDLE) ? req_addr : a_ff;
            if (MUX_MODE) begin
                bus.address_latch_strobe <= (st_ff == EH_ALE) && !done;
                bus.write_strobe_n       <= !((st_ff == EH_STROBE) && !done);
                bus.data_h2d_oe <= (st_ff == EH_SEL || st_ff == EH_ALE)
                                   || (wr_ff && st_ff != EH_IDLE && st_ff != EH_READ);
                bus.data_h2d    <= (st_ff == EH_SEL || st_ff == EH_ALE)
                                   ? {1'b0, a_ff} : d_ff;
            end else begin
                // Tied strobes in separate-bus mode.
                bus.write_strobe_n       <= !((st_ff == EH_STROBE) && !done);
                bus.address_latch_strobe <= !((st_ff == EH_STROBE) && !done);
                bus.data_h2d_oe          <= wr_ff && st_ff != EH_IDLE && st_ff != EH_READ;
                bus.data_h2d             <= d_ff;
            end
        end
    end
endmodule

// ### tb/epm_props.sv
`timescale 1ns/1ns
module epm_props #(
    parameter int PROG_PERIODS = 4
) (
    input wire logic                       core_clk,
    input wire logic                       rst_n,
    input wire logic                       data_h2d_oe,
    input wire logic [epm_pkg::DATA_W-1:0] data_d2h,
    input wire logic                       data_d2h_oe,
    input wire logic                       chip_select_n,
    input wire logic                       output_gate_n,
    input wire logic                       write_strobe_n,
    input wire logic                       address_latch_strobe,
    input wire logic                       prog_clk,
    input wire logic                       program_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic        pclk_d_ff;
    logic        we_d_ff;
    logic [15:0] pclk_cnt_ff;
    logic [3:0]  since_we_ff;

    always_ff @(posedge core_clk) begin
        pclk_d_ff <= prog_clk;
        we_d_ff   <= write_strobe_n;
    end

    // Counts raw timing edges while busy; one edge of slack covers the synchroniser.
    always_ff @(posedge core_clk) begin
        if (!rst_n || program_status) begin
            pclk_cnt_ff <= 16'h0000;
        end else if (prog_clk && !pclk_d_ff) begin
            pclk_cnt_ff <= pclk_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || (write_strobe_n && !we_d_ff)) begin
            since_we_ff <= 4'h0;
        end else if (since_we_ff != 4'hF) begin
            since_we_ff <= since_we_ff + 4'h1;
        end
    end

    desel_float_a: assert property (chip_select_n [*4] |-> !data_d2h_oe)
        else $error("data driven while deselected");
    float_after_a: assert property (($rose(output_gate_n) || $rose(chip_select_n))
        |-> ##[0:3] !data_d2h_oe) else $error("data not floated in time");
    read_drive_a: assert property ($fell(output_gate_n) && !chip_select_n && program_status
        |-> ##[1:3] data_d2h_oe) else $error("read data late");
    read_hold_a: assert property (data_d2h_oe && !output_gate_n && !chip_select_n
        |=> data_d2h_oe || output_gate_n || chip_select_n) else $error("read data dropped");
    busy_ignore_a: assert property (!program_status [*3] |-> !data_d2h_oe)
        else $error("read served while busy");
    busy_len_a: assert property ($rose(program_status) |->
        pclk_cnt_ff >= PROG_PERIODS - 1 && pclk_cnt_ff <= PROG_PERIODS + 1)
        else $error("busy length wrong");
    busy_end_a: assert property (!program_status |-> pclk_cnt_ff <= PROG_PERIODS + 1)
        else $error("busy never ends");
    write_busy_a: assert property ($rose(write_strobe_n) && !chip_select_n && program_status
        |-> ##[1:6] !program_status) else $error("status delay too long");
    no_spurious_a: assert property ($fell(program_status) |-> since_we_ff <= 4'h6)
        else $error("busy without write");
    ale_width_a: assert property ($rose(address_latch_strobe) |-> address_latch_strobe [*4])
        else $error("latch strobe short");
    we_width_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
        else $error("write strobe short");
    cs_lead_a: assert property ($rose(address_latch_strobe) |-> !$past(chip_select_n, 2))
        else $error("select lead short");
    float_gate_a: assert property ($fell(output_gate_n) |-> !data_h2d_oe && !$past(data_h2d_oe))
        else $error("address not floated");
    read_stable_a: assert property (data_d2h_oe && $past(data_d2h_oe)
        |-> $stable(data_d2h)) else $error("read data changed");

    write_c: cover property ($fell(program_status));
    read_c: cover property (data_d2h_oe && !output_gate_n);
    done_c: cover property ($rose(program_status));
    strobe_c: cover property ($rose(write_strobe_n) && !chip_select_n);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int PROG_N = 4;
    localparam int DIV_N  = 4;
    localparam logic [epm_pkg::ADDR_W-1:0] ADDRS [4] = '{7'h00, 7'h7F, 7'h2A, 7'h55};
    localparam logic [epm_pkg::DATA_W-1:0] DATS  [4] = '{8'hA5, 8'h5A, 8'h01, 8'hFE};

    logic                       core_clk;
    logic                       rst_n;
    logic                       clk_en;
    logic                       req_valid [2];
    logic                       req_write [2];
    logic [epm_pkg::ADDR_W-1:0] req_addr  [2];
    logic [epm_pkg::DATA_W-1:0] req_wdata [2];
    logic                       req_ready [2];
    logic                       rsp_valid [2];
    logic [epm_pkg::DATA_W-1:0] rsp_rdata [2];
    logic                       dev_busy  [2];
    logic [epm_pkg::DATA_W-1:0] got;
    int                         failures;
    int                         cmp_count;
    wire                        pin_oe     [2];
    wire  [epm_pkg::DATA_W-1:0] pin_bus    [2];
    wire                        pin_status [2];

    // Pair 0 runs the multiplexed bus, pair 1 the separate buses.
    epm_if ifc [2] ();

    for (genvar k = 0; k < 2; k++) begin : g_pair
        epm_host #(.PCLK_DIV(DIV_N), .MUX_MODE(k == 0)) epm_host_i (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .clk_en    (clk_en),
            .req_valid (req_valid[k]),
            .req_write (req_write[k]),
            .req_addr  (req_addr[k]),
            .req_wdata (req_wdata[k]),
            .req_ready (req_ready[k]),
            .rsp_valid (rsp_valid[k]),
            .rsp_rdata (rsp_rdata[k]),
            .dev_busy  (dev_busy[k]),
            .bus       (ifc[k])
        );
        epm_device #(.PROG_PERIODS(PROG_N), .MUX_MODE(k == 0)) epm_device_i (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .clk_en   (clk_en),
            .bus      (ifc[k])
        );
        // Constant indices here, so the tasks can pick a pair by a variable.
        assign pin_oe[k]     = ifc[k].data_d2h_oe;
        assign pin_bus[k]    = ifc[k].data_bus;
        assign pin_status[k] = ifc[k].program_status;
    end

    epm_props #(.PROG_PERIODS(PROG_N)) epm_props_i (
        .core_clk             (core_clk),
        .rst_n                (rst_n),
        .data_h2d_oe          (ifc[0].data_h2d_oe),
        .data_d2h             (ifc[0].data_d2h),
        .data_d2h_oe          (ifc[0].data_d2h_oe),
        .chip_select_n        (ifc[0].chip_select_n),
        .output_gate_n        (ifc[0].output_gate_n),
        .write_strobe_n       (ifc[0].write_strobe_n),
        .address_latch_strobe (ifc[0].address_latch_strobe),
        .prog_clk             (ifc[0].prog_clk),
        .program_status       (ifc[0].program_status)
    );

    task automatic check1(input string name, input logic exp, input logic seen);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", name, exp, seen);
        end
    endtask

    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", name, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // Entered just after an edge; one edge passes first so valid is never set twice at once.
    task automatic issue(input int k, input logic wr, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        tick();
        req_valid[k] = 1'b1;
        req_write[k] = wr;
        req_addr[k]  = a;
        req_wdata[k] = d;
        while (req_ready[k] !== 1'b1 && n < 5000) begin
            tick();
            n++;
        end
        check1("request taken", 1'b1, n < 5000);
        tick();
        req_valid[k] = 1'b0;
    endtask

    task automatic wr(input int k, input logic [6:0] a, input logic [7:0] d);
        int n;
        int busy_n;
        logic len_ok;
        n = 0;
        busy_n = 0;
        issue(k, 1'b1, a, d);
        while (dev_busy[k] !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        check1("busy seen", 1'b1, dev_busy[k]);
        check1("ready while busy", 1'b0, req_ready[k]);
        while (dev_busy[k] === 1'b1 && busy_n < 5000) begin
            tick();
            busy_n++;
        end
        len_ok = busy_n >= (PROG_N - 1) * DIV_N && busy_n <= (PROG_N + 1) * DIV_N + 8;
        check1("busy length", 1'b1, len_ok);
        check1("ready after busy", 1'b1, req_ready[k]);
    endtask

    task automatic rd(input int k, input logic [6:0] a, output logic [7:0] d);
        int n;
        n = 0;
        issue(k, 1'b0, a, 8'h00);
        while (rsp_valid[k] !== 1'b1 && n < 500) begin
            tick();
            n++;
        end
        d = rsp_rdata[k];
        repeat (4) tick();
        check1("idle float", 1'b0, pin_oe[k]);
        check8("idle bus", 8'hFF, pin_bus[k]);
        check1("idle status", 1'b1, pin_status[k]);
    endtask

    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        failures = 0;
        cmp_count = 0;
        for (int k = 0; k < 2; k++) begin
            req_valid[k] = 1'b0;
            req_write[k] = 1'b0;
            req_addr[k]  = 7'h00;
            req_wdata[k] = 8'h00;
        end
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (4) tick();
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                wr(k, ADDRS[i], DATS[i]);
            end
            for (int i = 0; i < 4; i++) begin
                rd(k, ADDRS[i], got);
                check8("read back", DATS[i], got);
            end
            // Rewriting a word must replace it, not merge with the old bits.
            wr(k, ADDRS[1], ~DATS[1]);
            rd(k, ADDRS[1], got);
            check8("rewrite", ~DATS[1], got);
            rd(k, ADDRS[0], got);
            check8("neighbour kept", DATS[0], got);
        end
        end_sim();
    end
endmodule
